/* bench/tmo_pin_model.sv */
// model of the two external timer input pins
`timescale 1ns/10ps
module tmo_pin_model (
   input  wire logic       clk,
   output logic      [1:0] pin
);
   // each level stands four clocks so the pin sampler cannot miss it
   task automatic drive(input logic [1:0] v);
      pin = v;
      repeat (4) @(negedge clk);
   endtask
   initial pin = 2'b00;
endmodule

/* bench/tmo_top_chk.sv */
// port-level assertions for the timer output block
`timescale 1ns/10ps
`include "tmo_regs.svh"
module tmo_top_chk
   import tmo_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire tmo_mode_t   mode_field,
   input wire tmo_count_t  main_counter,
   input wire logic        first_match_irq,
   input wire logic        second_match_irq,
   input wire logic        timer_output
);
   logic [7:0] toc_ff;
   logic       wrq_ff;
   wire        toc_wr = reg_wr && reg_addr == `TMO_TOC_ADDR;
   wire        ev     = (first_match_irq && toc_ff[1]) || (second_match_irq && toc_ff[4]);
   // a write one cycle back may legally override a toggle, so it is excluded
   wire        quiet  = !wrq_ff && toc_ff[0];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         toc_ff <= 8'h00;
         wrq_ff <= 1'b0;
      end else begin
         wrq_ff <= toc_wr;
         if (toc_wr) toc_ff <= reg_wdata & 8'h33;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence lvl_wr(logic [1:0] v);
      toc_wr && reg_wdata[3:2] == v && reg_wdata[0] && toc_ff[0];
   endsequence
   set_high_a: assert property (lvl_wr(2'h2) |=> timer_output) else $error("set missed");
   clr_low_a: assert property (lvl_wr(2'h1) |=> !timer_output) else $error("clear missed");
   out_off_a: assert property (!toc_ff[0] && !$past(toc_ff[0]) |-> !timer_output)
      else $error("output not low");
   rd_back_a: assert property (reg_rd && !reg_wr && reg_addr == `TMO_TOC_ADDR
      |=> reg_rdata == toc_ff) else $error("control readback");
   tog_ev_a: assert property (quiet && !toc_ff[5] && ev
      |-> timer_output != $past(timer_output)) else $error("no toggle");
   hold_out_a: assert property (quiet && !ev |-> $stable(timer_output))
      else $error("stray toggle");
   stop_clr_a: assert property (mode_field == `TMO_MODE_STOP |=> main_counter == 16'h0000)
      else $error("counter not cleared");
   trig_clr_a: assert property (toc_wr && reg_wdata[6] && mode_field != 2'h0
      |=> main_counter == 16'h0000) else $error("trigger no clear");
endmodule
bind tmo_top tmo_top_chk chk_i (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
   .reg_rdata, .mode_field, .main_counter, .first_match_irq, .second_match_irq, .timer_output);

/* bench/tmo_top_tb.sv */
// self-checking bench for the timer output and prescaler block
`timescale 1ns/10ps
`include "tmo_regs.svh"
module tmo_top_tb;
   logic        clk, rst_b, reg_wr, reg_rd, first_match_irq, second_match_irq;
   logic        first_edge_event, second_edge_event, timer_output;
   logic [15:0] reg_addr, main_counter, cc1, cc2;
   logic [15:0] cyc = 16'h0000;
   logic [7:0]  reg_wdata, reg_rdata, v;
   logic [1:0]  mode_field, pins;
   int          failures = 0, checks_done = 0, n1, n2, c, seed = 32'h8916f5df;
   tmo_top dut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mode_field,
      .first_capcomp_reg(cc1), .second_capcomp_reg(cc2), .first_timer_input(pins[0]),
      .second_timer_input(pins[1]), .sub_clk_in(cyc[3]), .aux_8bit_timer(cyc[2]),
      .main_counter, .first_match_irq, .second_match_irq, .first_edge_event,
      .second_edge_event, .timer_output);
   tmo_pin_model pm (.clk, .pin(pins));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) cyc <= cyc + 16'h0001;
   always @(posedge clk) begin
      n1 += int'(first_edge_event === 1'b1);
      n2 += int'(second_edge_event === 1'b1);
   end
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // counts cross unsynchronised dividers, so two ticks of slack are allowed
   task automatic near(input logic [15:0] g, input int e);
      checks_done++;
      if ($isunknown(g) || int'(g) < e - 2 || int'(g) > e + 2) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e[15:0]);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk({8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic wait_irq(input logic sec, input logic e);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((sec ? second_match_irq : first_match_irq) !== 1'b1 && n < 70000);
      if ((sec ? second_match_irq : first_match_irq) !== 1'b1) begin
         failures++;
         finish_test();
      end
      chk({15'h0, timer_output}, {15'h0, e});
   endtask
   function automatic logic [1:0] ecode();
      logic [1:0] r;
      r = 2'($random(seed));
      return (r == 2'h2) ? `TMO_EDGE_BOTH : r;
   endfunction
   function automatic int ticks(input int k, input logic [1:0] e);
      int sh [8] = '{0, 1, 2, 4, 8, 4, 0, 3};
      if (k == 6) return (e == `TMO_EDGE_BOTH) ? 128 : 64;
      return 512 >> sh[k];
   endfunction
   initial begin
      rst_b = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, mode_field} = '0;
      cc2 = 16'h0010 + 16'($random(seed) & 63);
      cc1 = cc2 + 16'h0010 + 16'($random(seed) & 63);
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      rdc(`TMO_PRM_ADDR, `TMO_PRM_RESET);
      rdc(`TMO_TOC_ADDR, `TMO_TOC_RESET);
      rdc(16'hFFBC, 8'h00);
      wr(`TMO_PRM_ADDR, 8'h50);
      pm.drive(2'h3);
      n1 = 0;
      n2 = 0;
      for (c = 0; c < 2; c++) begin
         mode_field = `TMO_MODE_FREE;
         repeat (8) @(negedge clk);
         mode_field = `TMO_MODE_STOP;
         pm.drive(2'h3);
         chk(16'(n1 + n2), 16'h0002);
         chk(main_counter, 16'h0000);
      end
      pm.drive(2'h0);
      $display("first enable test done");
      for (c = 0; c < 8; c++) begin
         v = {ecode(), ecode(), 1'b1, 3'(c)};
         wr(`TMO_PRM_ADDR, v);
         rdc(`TMO_PRM_ADDR, v & 8'hF7);
         n1 = 0;
         n2 = 0;
         mode_field = `TMO_MODE_FREE;
         repeat (64) begin
            pm.drive(2'h3);
            pm.drive(2'h0);
         end
         near(main_counter, ticks(c, v[5:4]));
         near(16'(n1), ticks(6, v[5:4]));
         near(16'(n2), ticks(6, v[7:6]));
         mode_field = `TMO_MODE_STOP;
         @(negedge clk);
      end
      $display("prescaler test done");
      wr(`TMO_PRM_ADDR, 8'h00);
      wr(`TMO_TOC_ADDR, 8'h12);
      wr(`TMO_TOC_ADDR, 8'h13);
      wr(`TMO_TOC_ADDR, 8'h1B);
      chk({15'h0, timer_output}, 16'h0001);
      rdc(`TMO_TOC_ADDR, 8'h13);
      wr(`TMO_TOC_ADDR, 8'h17);
      chk({15'h0, timer_output}, 16'h0000);
      wr(`TMO_TOC_ADDR, 8'h1B);
      mode_field = `TMO_MODE_FREE;
      wait_irq(1'b1, 1'b0);
      wait_irq(1'b0, 1'b1);
      mode_field = `TMO_MODE_STOP;
      wr(`TMO_TOC_ADDR, 8'h33);
      mode_field = `TMO_MODE_FREE;
      wr(`TMO_TOC_ADDR, 8'h73);
      chk(main_counter, 16'h0000);
      wait_irq(1'b1, 1'b0);
      wait_irq(1'b0, 1'b1);
      wait_irq(1'b1, 1'b1);
      mode_field = `TMO_MODE_STOP;
      @(negedge clk);
      mode_field = `TMO_MODE_EDGE_CLR;
      pm.drive(2'h3);
      pm.drive(2'h0);
      chk(main_counter, 16'h0000);
      mode_field = `TMO_MODE_STOP;
      @(negedge clk);
      // one-shot select is still set here, so repeated toggles show it is ignored
      mode_field = `TMO_MODE_MATCH_CLR;
      wait_irq(1'b1, 1'b0);
      wait_irq(1'b0, 1'b1);
      chk(main_counter, 16'h0000);
      wait_irq(1'b1, 1'b0);
      mode_field = `TMO_MODE_STOP;
      wr(`TMO_TOC_ADDR, 8'h12);
      repeat (2) @(negedge clk);
      chk({15'h0, timer_output}, 16'h0000);
      rdc(`TMO_TOC_ADDR, 8'h12);
      $display("output test done");
      finish_test();
   end
endmodule

/* logic/tmo_edge_det.sv */
// pin synchroniser and valid-edge detector with first-enable rising-edge behaviour
`timescale 1ns/10ps
`include "tmo_regs.svh"
module tmo_edge_det
   import tmo_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_b,
   input  wire logic      pin,
   input  wire logic      enable,
   input  wire tmo_edge_t edge_sel,
   output logic           edge_pulse
);
   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic started_ff;
   logic pulse_ff;
   wire  rise_seen;
   wire  fall_seen;
   wire  hit;

   assign rise_seen = sync2_ff & ~prev_ff;
   assign fall_seen = ~sync2_ff & prev_ff;
   assign hit = (edge_sel == `TMO_EDGE_FALL) ? fall_seen :
                (edge_sel == `TMO_EDGE_RISE) ? rise_seen :
                (edge_sel == `TMO_EDGE_BOTH) ? (rise_seen | fall_seen) : 1'b0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
      end
   end

   // prev holds low until the first enable, so a high pin then looks like a rising edge;
   // afterwards it tracks the pin even while stopped, so a restart sees no edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         started_ff <= 1'b0;
         prev_ff    <= 1'b0;
      end else begin
         started_ff <= started_ff | enable;
         if (started_ff | enable) begin
            prev_ff <= sync2_ff;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= enable & hit;
      end
   end

   assign edge_pulse = pulse_ff;
endmodule

/* logic/tmo_top.sv */
// timer output control, prescaler, edge selection and counter of the 16-bit timer
`timescale 1ns/10ps
`include "tmo_regs.svh"
module tmo_top
   import tmo_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire tmo_mode_t   mode_field,
   input  wire tmo_count_t  first_capcomp_reg,
   input  wire tmo_count_t  second_capcomp_reg,
   input  wire logic        first_timer_input,
   input  wire logic        second_timer_input,
   input  wire logic        sub_clk_in,
   input  wire logic        aux_8bit_timer,
   output tmo_count_t       main_counter,
   output logic             first_match_irq,
   output logic             second_match_irq,
   output logic             first_edge_event,
   output logic             second_edge_event,
   output logic             timer_output
);
   // stored register bits
   logic        oneshot_select_ff;
   logic        second_match_invert_en_ff;
   logic        first_match_invert_en_ff;
   logic        output_enable_ff;
   tmo_edge_t   second_edge_sel_ff;
   tmo_edge_t   first_edge_sel_ff;
   tmo_clksel_t clk_sel_ff;
   logic [7:0]  rdata_ff;

   // counter, prescaler and output state
   tmo_count_t  cnt_ff;
   tmo_count_t  nxt_cnt;
   logic [7:0]  pre_ff;
   logic        aux_prev_ff;
   logic        first_match_ff;
   logic        second_match_ff;
   logic        out_ff;
   logic        nxt_out;
   logic        armed_ff;
   logic        nxt_armed;

   // decode
   wire         running;
   wire         sel_prm;
   wire         sel_toc;
   wire         wr_prm;
   wire         wr_toc;
   wire         sw_trigger;
   wire         lvl_set;
   wire         lvl_rst;
   wire         first_edge;
   wire         second_edge;
   wire         sub_edge;
   wire         aux_rise;
   wire         count_tick;
   wire         at_first;
   wire         at_second;
   wire         hit_first;
   wire         hit_second;
   wire         oneshot_on;
   wire         edge_restart;
   wire         inv_first;
   wire         inv_second;
   wire         toggle;
   wire [7:0]   toc_read;
   wire [7:0]   prm_read;

   assign running = (mode_field != `TMO_MODE_STOP);
   assign sel_prm = (reg_addr == `TMO_PRM_ADDR);
   assign sel_toc = (reg_addr == `TMO_TOC_ADDR);
   assign wr_prm  = reg_wr & sel_prm;
   assign wr_toc  = reg_wr & sel_toc;

   // trigger bits act on the write itself and are never stored
   assign sw_trigger = wr_toc & reg_wdata[`TMO_TOC_OS_TRIG] & running;
   assign lvl_set    = wr_toc & reg_wdata[`TMO_TOC_LVL_SET]
                       & ~reg_wdata[`TMO_TOC_LVL_RST];
   assign lvl_rst    = wr_toc & reg_wdata[`TMO_TOC_LVL_RST]
                       & ~reg_wdata[`TMO_TOC_LVL_SET];

   tmo_edge_det u_first_edge (
      .clk        (clk),
      .rst_b      (rst_b),
      .pin        (first_timer_input),
      .enable     (running),
      .edge_sel   (first_edge_sel_ff),
      .edge_pulse (first_edge)
   );

   tmo_edge_det u_second_edge (
      .clk        (clk),
      .rst_b      (rst_b),
      .pin        (second_timer_input),
      .enable     (running),
      .edge_sel   (second_edge_sel_ff),
      .edge_pulse (second_edge)
   );

   // the subsystem clock is slow against clk, so each of its rising edges is one tick
   tmo_edge_det u_sub_edge (
      .clk        (clk),
      .rst_b      (rst_b),
      .pin        (sub_clk_in),
      .enable     (running),
      .edge_sel   (`TMO_EDGE_RISE),
      .edge_pulse (sub_edge)
   );

   assign aux_rise = aux_8bit_timer & ~aux_prev_ff;

   // count clock is gated off entirely while stopped
   assign count_tick = ~running ? 1'b0 :
                       (clk_sel_ff == `TMO_CS_PCLK)   ? 1'b1 :
                       (clk_sel_ff == `TMO_CS_DIV2)   ? (pre_ff[0] == 1'b1) :
                       (clk_sel_ff == `TMO_CS_DIV4)   ? (pre_ff[1:0] == 2'h3) :
                       (clk_sel_ff == `TMO_CS_DIV16)  ? (pre_ff[3:0] == 4'hF) :
                       (clk_sel_ff == `TMO_CS_DIV256) ? (pre_ff == 8'hFF) :
                       (clk_sel_ff == `TMO_CS_SUB)    ? sub_edge :
                       (clk_sel_ff == `TMO_CS_EDGE1)  ? first_edge :
                       aux_rise;

   assign at_first   = (cnt_ff == first_capcomp_reg);
   assign at_second  = (cnt_ff == second_capcomp_reg);
   assign hit_first  = count_tick & at_first;
   assign hit_second = count_tick & at_second;

   // one-shot is ignored in match-clear mode
   assign oneshot_on = oneshot_select_ff & ((mode_field == `TMO_MODE_FREE) |
                       (mode_field == `TMO_MODE_EDGE_CLR));
   assign edge_restart = (mode_field == `TMO_MODE_EDGE_CLR) & first_edge
                         & (clk_sel_ff != `TMO_CS_EDGE1);

   assign inv_first  = hit_first & first_match_invert_en_ff
                       & (~oneshot_on | armed_ff);
   assign inv_second = hit_second & second_match_invert_en_ff
                       & (~oneshot_on | armed_ff);
   assign toggle     = inv_first | inv_second;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (!running) begin
         nxt_cnt = 16'h0000;
      end else if (sw_trigger | edge_restart) begin
         nxt_cnt = 16'h0000;
      end else if (count_tick) begin
         if ((mode_field == `TMO_MODE_MATCH_CLR) & at_first) begin
            nxt_cnt = 16'h0000;
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
         end
      end
   end

   always_comb begin
      nxt_armed = armed_ff;
      if (!oneshot_on) begin
         nxt_armed = 1'b0;
      end else if (sw_trigger | edge_restart) begin
         nxt_armed = 1'b1;
      end else if (inv_first) begin
         nxt_armed = 1'b0;
      end
   end

   always_comb begin
      nxt_out = out_ff;
      if (!output_enable_ff) begin
         nxt_out = 1'b0;
      end else if (lvl_set) begin
         nxt_out = 1'b1;
      end else if (lvl_rst) begin
         nxt_out = 1'b0;
      end else if (toggle) begin
         nxt_out = ~out_ff;
      end
   end

   // a software clear of a level bit does nothing: only a written one reaches nxt_out
   assign toc_read = {2'b00, oneshot_select_ff, second_match_invert_en_ff,
                      2'b00, first_match_invert_en_ff, output_enable_ff};
   assign prm_read = {second_edge_sel_ff, first_edge_sel_ff, 1'b0, clk_sel_ff};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oneshot_select_ff         <= 1'b0;
         second_match_invert_en_ff <= 1'b0;
         first_match_invert_en_ff  <= 1'b0;
         output_enable_ff          <= 1'b0;
      end else if (wr_toc) begin
         oneshot_select_ff         <= reg_wdata[`TMO_TOC_OS_SEL];
         second_match_invert_en_ff <= reg_wdata[`TMO_TOC_INV2_EN];
         first_match_invert_en_ff  <= reg_wdata[`TMO_TOC_INV1_EN];
         output_enable_ff          <= reg_wdata[`TMO_TOC_OUT_EN];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         second_edge_sel_ff <= `TMO_EDGE_FALL;
         first_edge_sel_ff  <= `TMO_EDGE_FALL;
         clk_sel_ff         <= `TMO_CS_PCLK;
      end else if (wr_prm) begin
         second_edge_sel_ff <= reg_wdata[`TMO_PRM_ES2_HI:`TMO_PRM_ES2_LO];
         first_edge_sel_ff  <= reg_wdata[`TMO_PRM_ES1_HI:`TMO_PRM_ES1_LO];
         clk_sel_ff         <= reg_wdata[`TMO_PRM_CS_HI:`TMO_PRM_CS_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         rdata_ff <= sel_toc ? toc_read : (sel_prm ? prm_read : 8'h00);
      end
   end

   // prescaler runs freely; dividers tap it so a restart does not re-phase them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff      <= 8'h00;
         aux_prev_ff <= 1'b0;
      end else begin
         pre_ff      <= pre_ff + 8'h01;
         aux_prev_ff <= aux_8bit_timer;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff   <= 16'h0000;
         armed_ff <= 1'b0;
         out_ff   <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         armed_ff <= nxt_armed;
         out_ff   <= nxt_out;
      end
   end

   // match interrupts are raised whatever the inversion enables say
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         first_match_ff  <= 1'b0;
         second_match_ff <= 1'b0;
      end else begin
         first_match_ff  <= hit_first;
         second_match_ff <= hit_second;
      end
   end

   assign reg_rdata         = rdata_ff;
   assign main_counter      = cnt_ff;
   assign first_match_irq   = first_match_ff;
   assign second_match_irq  = second_match_ff;
   assign first_edge_event  = first_edge;
   assign second_edge_event = second_edge;
   assign timer_output      = out_ff;
endmodule

/* pkg/tmo_pkg.sv */
// types shared by the timer output and prescaler block
package tmo_pkg;
   typedef logic [1:0]  tmo_mode_t;
   typedef logic [1:0]  tmo_edge_t;
   typedef logic [2:0]  tmo_clksel_t;
   typedef logic [15:0] tmo_count_t;
endpackage

/* pkg/tmo_regs.svh */
// register offsets, field positions, reset values and codes of the timer output block
`ifndef TMO_REGS_SVH
`define TMO_REGS_SVH

`define TMO_PRM_ADDR        16'hFFBB
`define TMO_TOC_ADDR        16'hFFBD
`define TMO_PRM_RESET       8'h00
`define TMO_TOC_RESET       8'h00

`define TMO_TOC_OS_TRIG     6
`define TMO_TOC_OS_SEL      5
`define TMO_TOC_INV2_EN     4
`define TMO_TOC_LVL_SET     3
`define TMO_TOC_LVL_RST     2
`define TMO_TOC_INV1_EN     1
`define TMO_TOC_OUT_EN      0

`define TMO_PRM_ES2_HI      7
`define TMO_PRM_ES2_LO      6
`define TMO_PRM_ES1_HI      5
`define TMO_PRM_ES1_LO      4
`define TMO_PRM_CS_HI       2
`define TMO_PRM_CS_LO       0

`define TMO_EDGE_FALL       2'h0
`define TMO_EDGE_RISE       2'h1
`define TMO_EDGE_BOTH       2'h3

`define TMO_CS_PCLK         3'h0
`define TMO_CS_DIV2         3'h1
`define TMO_CS_DIV4         3'h2
`define TMO_CS_DIV16        3'h3
`define TMO_CS_DIV256       3'h4
`define TMO_CS_SUB          3'h5
`define TMO_CS_EDGE1        3'h6
`define TMO_CS_AUX          3'h7

`define TMO_MODE_STOP       2'h0
`define TMO_MODE_FREE       2'h1
`define TMO_MODE_EDGE_CLR   2'h2
`define TMO_MODE_MATCH_CLR  2'h3

`endif
